// >>> rtl/ccx_cfg.svh
// Register indices, field positions, reset values and timing constants of the CCA extension bank
`ifndef CCX_CFG_SVH
`define CCX_CFG_SVH

`define CCX_IDX_RX_STATUS 9'h01f
`define CCX_IDX_CMD 9'h0f0
`define CCX_IDX_STATE 9'h0f1
`define CCX_IDX_CFG_A 9'h103
`define CCX_IDX_CFG_B 9'h104
`define CCX_IDX_THRESH 9'h105
`define CCX_IDX_RX_ANT 9'h129
`define CCX_IDX_TX_ANT 9'h12a
`define CCX_IDX_ANT0_RSSI 9'h12b
`define CCX_IDX_ANT1_RSSI 9'h12c
`define CCX_IDX_MARGIN 9'h12d
`define CCX_IDX_PRE_LO 9'h12e
`define CCX_IDX_PRE_HI 9'h12f
`define CCX_IDX_SFD_LO 9'h130
`define CCX_IDX_SFD_HI 9'h131
`define CCX_IDX_PHR_LO 9'h132
`define CCX_IDX_PHR_HI 9'h133
`define CCX_IDX_RXB_SIG 9'h134
`define CCX_IDX_RXB_SIZE 9'h135
`define CCX_IDX_TXB_SIG 9'h136
`define CCX_IDX_TXB_SIZE 9'h137
`define CCX_IDX_TESTMODE 9'h139
`define CCX_IDX_VCO_BAND 9'h13b
`define CCX_IDX_VCO_AMP 9'h13c

`define CCX_BIT_BUSY 7
`define CCX_BIT_HOLD_TX 4
`define CCX_BIT_FREEZE 0
`define CCX_BIT_DIV_EN 0
`define CCX_RST_BYTE 8'h00

`define CCX_CMD_RX_ASSESS 8'hb2
`define CCX_CMD_TX 8'hb5
`define CCX_CMD_ON 8'hb1
`define CCX_CMD_CCA_START 8'hb7
`define CCX_CMD_CCA_STOP 8'hb8

`define CCX_CODE_ON 8'h18
`define CCX_CODE_RX 8'h1a
`define CCX_CODE_TX 8'h1c

`define CCX_CLK_MHZ 50
`define CCX_TIMER_INFINITE 3'h7
`define CCX_T0_US 14'd160
`define CCX_T1_US 14'd320
`define CCX_T2_US 14'd640
`define CCX_T3_US 14'd1280
`define CCX_T4_US 14'd1920
`define CCX_T5_US 14'd2560
`define CCX_T6_US 14'd9960

`endif

// >>> rtl/ccx_pkg.sv
// Types shared by the CCA extension register bank
package ccx_pkg;

	typedef enum logic [1:0] {
		CCX_ST_ON,
		CCX_ST_RX_ASSESS,
		CCX_ST_TX
	} ccx_state_t;

	typedef struct packed {
		ccx_state_t state;
		logic assess_run;
		logic [15:0] tick_cnt;
		logic [13:0] us_cnt;
		logic tx_start;
		logic wait_n;
		logic [31:0] rdata;
		logic [7:0] rx_status;
		logic [7:0] cfg_a;
		logic [7:0] cfg_b;
		logic [7:0] thresh;
		logic [7:0] rx_ant;
		logic [7:0] tx_ant;
		logic [7:0] ant0_rssi;
		logic [7:0] ant1_rssi;
		logic [7:0] margin;
		logic [15:0] preamble;
		logic [15:0] sfd;
		logic [15:0] phr;
		logic [7:0] rxb_sig;
		logic [7:0] rxb_size;
		logic [7:0] txb_sig;
		logic [7:0] txb_size;
		logic [7:0] testmode;
		logic [7:0] vco_band;
		logic [7:0] vco_amp;
	} ccx_regs_t;

endpackage

// >>> rtl/ccx_regs.sv
// CCA and PHY extension register bank with assessment timer and radio state control
`timescale 1ns/1ps
`default_nettype none
`include "ccx_cfg.svh"

module ccx_regs
	import ccx_pkg::*;
#(
	parameter int TICK_CYCLES = `CCX_CLK_MHZ
)
(
	input wire logic clk_sys, // 50 MHz system clock
	input wire logic rst, // Synchronous reset, active high
	input wire logic [8:0] avs_address, // Word address, equals register index
	input wire logic avs_read, // Read request
	input wire logic avs_write, // Write request
	input wire logic [3:0] avs_byteenable, // Byte lanes, only lane 0 is stored
	input wire logic [31:0] avs_writedata, // Write data
	output logic [31:0] avs_readdata, // Read data, valid while waitrequest low
	output logic avs_waitrequest, // Low for one cycle to finish a request
	input wire logic rssi_valid, // Pulse: new signal level measurement
	input wire logic [7:0] rssi_level, // Measured level, threshold scale
	input wire logic rssi_antenna, // Antenna the measurement came from
	input wire logic rx_byte_strobe, // Pulse: one byte received
	input wire logic preamble_detected, // Receiver preamble detect level
	input wire logic sfd_detected, // Receiver frame delimiter detect level
	input wire logic cal_valid, // Pulse: oscillator calibration finished
	input wire logic [7:0] cal_band, // Calibrated band selection
	input wire logic [7:0] cal_amplitude, // Calibrated amplitude level
	input wire logic tx_done, // Pulse: transmission finished
	output logic [1:0] assessment_if_bandwidth, // IF filter bandwidth code
	output logic channel_busy_flag, // Current assessment result
	output logic assess_active, // Assessment timer running
	output logic tx_start, // Pulse: begin a transmission
	output logic [7:0] radio_state, // State code of the radio
	output logic [15:0] preamble_bytes, // Transmit preamble length in bytes
	output logic [15:0] frame_delimiter, // Delimiter word
	output logic [15:0] phy_header, // PHY header word
	output logic [7:0] rx_buf_level, // Receive buffer nearly-full level
	output logic [7:0] rx_buf_size, // Receive buffer full size
	output logic [7:0] tx_buf_level, // Transmit buffer nearly-full level
	output logic [7:0] tx_buf_size, // Transmit buffer full size
	output logic [7:0] rx_antenna_cfg, // Receive antenna configuration
	output logic [7:0] tx_antenna_cfg, // Transmit antenna configuration
	output logic [7:0] test_mode // Test mode control
);

	ccx_regs_t q_q;
	ccx_regs_t q_d;

	logic req;
	logic take;
	logic wr_hit;
	logic [7:0] wbyte;
	logic [13:0] limit_us;
	logic infinite;
	logic expire;

	function automatic logic [13:0] duration_us(input logic [2:0] sel);
		unique case (sel)
			3'h0: duration_us = `CCX_T0_US;
			3'h1: duration_us = `CCX_T1_US;
			3'h2: duration_us = `CCX_T2_US;
			3'h3: duration_us = `CCX_T3_US;
			3'h4: duration_us = `CCX_T4_US;
			3'h5: duration_us = `CCX_T5_US;
			default: duration_us = `CCX_T6_US;
		endcase
	endfunction

	function automatic logic [7:0] state_code(input ccx_state_t s);
		unique case (s)
			CCX_ST_ON: state_code = `CCX_CODE_ON;
			CCX_ST_RX_ASSESS: state_code = `CCX_CODE_RX;
			CCX_ST_TX: state_code = `CCX_CODE_TX;
		endcase
	endfunction

	function automatic logic [7:0] read_mux(input ccx_regs_t r, input logic [8:0] idx);
		read_mux = 8'h00;
		unique case (idx)
			`CCX_IDX_RX_STATUS: read_mux = r.rx_status;
			`CCX_IDX_STATE: read_mux = state_code(r.state);
			`CCX_IDX_CFG_A: read_mux = r.cfg_a;
			`CCX_IDX_CFG_B: read_mux = r.cfg_b;
			`CCX_IDX_THRESH: read_mux = r.thresh;
			`CCX_IDX_RX_ANT: read_mux = r.rx_ant;
			`CCX_IDX_TX_ANT: read_mux = r.tx_ant;
			`CCX_IDX_ANT0_RSSI: read_mux = r.ant0_rssi;
			`CCX_IDX_ANT1_RSSI: read_mux = r.ant1_rssi;
			`CCX_IDX_MARGIN: read_mux = r.margin;
			`CCX_IDX_PRE_LO: read_mux = r.preamble[7:0];
			`CCX_IDX_PRE_HI: read_mux = r.preamble[15:8];
			`CCX_IDX_SFD_LO: read_mux = r.sfd[7:0];
			`CCX_IDX_SFD_HI: read_mux = r.sfd[15:8];
			`CCX_IDX_PHR_LO: read_mux = r.phr[7:0];
			`CCX_IDX_PHR_HI: read_mux = r.phr[15:8];
			`CCX_IDX_RXB_SIG: read_mux = r.rxb_sig;
			`CCX_IDX_RXB_SIZE: read_mux = r.rxb_size;
			`CCX_IDX_TXB_SIG: read_mux = r.txb_sig;
			`CCX_IDX_TXB_SIZE: read_mux = r.txb_size;
			`CCX_IDX_TESTMODE: read_mux = r.testmode;
			`CCX_IDX_VCO_BAND: read_mux = r.vco_band;
			`CCX_IDX_VCO_AMP: read_mux = r.vco_amp;
			default: read_mux = 8'h00;
		endcase
	endfunction

	assign req = avs_read | avs_write;
	// A request completes at the edge where waitrequest was low
	assign take = req & q_q.wait_n;
	assign wr_hit = take & avs_write & avs_byteenable[0];
	assign wbyte = avs_writedata[7:0];
	assign limit_us = duration_us(q_q.cfg_a[3:1]);
	assign infinite = (q_q.cfg_a[3:1] == `CCX_TIMER_INFINITE);
	assign expire = q_q.assess_run & ~infinite & (q_q.us_cnt >= limit_us);

	always_comb
	begin
		q_d = q_q;
		q_d.tx_start = 1'b0;
		q_d.wait_n = req & ~q_q.wait_n;
		if (req & ~q_q.wait_n)
		begin
			q_d.rdata = {24'h000000, read_mux(q_q, avs_address)};
		end
		q_d.rx_status = {6'h00, sfd_detected, preamble_detected};

		// Host writes; hardware updates below take precedence in the same cycle
		if (wr_hit)
		begin
			unique case (avs_address)
				`CCX_IDX_CFG_A: q_d.cfg_a = {q_q.cfg_a[`CCX_BIT_BUSY], wbyte[6:0]};
				`CCX_IDX_CFG_B: q_d.cfg_b = wbyte;
				`CCX_IDX_THRESH: q_d.thresh = wbyte;
				`CCX_IDX_RX_ANT: q_d.rx_ant = wbyte;
				`CCX_IDX_TX_ANT: q_d.tx_ant = wbyte;
				`CCX_IDX_ANT0_RSSI: q_d.ant0_rssi = wbyte;
				`CCX_IDX_ANT1_RSSI: q_d.ant1_rssi = wbyte;
				`CCX_IDX_MARGIN: q_d.margin = wbyte;
				`CCX_IDX_PRE_LO: q_d.preamble[7:0] = wbyte;
				`CCX_IDX_PRE_HI: q_d.preamble[15:8] = wbyte;
				`CCX_IDX_SFD_LO: q_d.sfd[7:0] = wbyte;
				`CCX_IDX_SFD_HI: q_d.sfd[15:8] = wbyte;
				`CCX_IDX_PHR_LO: q_d.phr[7:0] = wbyte;
				`CCX_IDX_PHR_HI: q_d.phr[15:8] = wbyte;
				`CCX_IDX_RXB_SIG: q_d.rxb_sig = wbyte;
				`CCX_IDX_RXB_SIZE: q_d.rxb_size = wbyte;
				`CCX_IDX_TXB_SIG: q_d.txb_sig = wbyte;
				`CCX_IDX_TXB_SIZE: q_d.txb_size = wbyte;
				`CCX_IDX_TESTMODE: q_d.testmode = wbyte;
				`CCX_IDX_VCO_BAND: q_d.vco_band = wbyte;
				`CCX_IDX_VCO_AMP: q_d.vco_amp = wbyte;
				default: ;
			endcase
		end

		// Measurements arrive without regard to the bus, so they overwrite a same-cycle host write
		if (rssi_valid & q_q.rx_ant[`CCX_BIT_DIV_EN])
		begin
			if (rssi_antenna)
				q_d.ant1_rssi = rssi_level;
			else
				q_d.ant0_rssi = rssi_level;
		end
		if (cal_valid)
		begin
			q_d.vco_band = cal_band;
			q_d.vco_amp = cal_amplitude;
		end

		// Per-byte refresh of the assessment result in the receive-assess state unless frozen for debug
		if (rx_byte_strobe & ~q_q.cfg_a[`CCX_BIT_FREEZE] & q_q.state == CCX_ST_RX_ASSESS)
		begin
			q_d.cfg_a[`CCX_BIT_BUSY] = (rssi_level > q_q.thresh);
			q_d.margin = q_q.thresh - rssi_level;
		end

		// Microsecond tick keeps the duration counter narrow at any clock rate
		if (q_q.assess_run)
		begin
			if (q_q.tick_cnt == 16'(TICK_CYCLES - 1))
			begin
				q_d.tick_cnt = 16'h0000;
				if (~infinite)
					q_d.us_cnt = q_q.us_cnt + 14'd1;
			end
			else
			begin
				q_d.tick_cnt = q_q.tick_cnt + 16'd1;
			end
		end

		unique case (q_q.state)
			CCX_ST_ON:
			begin
				q_d.assess_run = 1'b0;
			end
			CCX_ST_RX_ASSESS:
			begin
				if (expire)
				begin
					q_d.assess_run = 1'b0;
					// Auto transmit only on a clear channel; busy or hold keeps receiving
					if (~q_q.cfg_a[`CCX_BIT_HOLD_TX] & ~q_q.cfg_a[`CCX_BIT_BUSY])
					begin
						q_d.state = CCX_ST_TX;
						q_d.tx_start = 1'b1;
					end
				end
			end
			CCX_ST_TX:
			begin
				q_d.assess_run = 1'b0;
				if (tx_done)
					q_d.state = CCX_ST_ON;
			end
		endcase

		// Commands are written to the command register
		if (wr_hit & avs_address == `CCX_IDX_CMD)
		begin
			unique case (wbyte)
				`CCX_CMD_RX_ASSESS:
				begin
					q_d.state = CCX_ST_RX_ASSESS;
					q_d.assess_run = 1'b0;
				end
				`CCX_CMD_TX:
				begin
					if (q_q.state != CCX_ST_TX)
					begin
						q_d.state = CCX_ST_TX;
						q_d.tx_start = 1'b1;
						q_d.assess_run = 1'b0;
					end
				end
				`CCX_CMD_ON:
				begin
					q_d.state = CCX_ST_ON;
					q_d.assess_run = 1'b0;
				end
				`CCX_CMD_CCA_START:
				begin
					if (q_q.state == CCX_ST_RX_ASSESS)
					begin
						q_d.assess_run = 1'b1;
						q_d.tick_cnt = 16'h0000;
						q_d.us_cnt = 14'd0;
					end
				end
				`CCX_CMD_CCA_STOP:
				begin
					q_d.assess_run = 1'b0;
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			q_q <= '0;
			q_q.state <= CCX_ST_ON;
		end
		else
		begin
			q_q <= q_d;
		end
	end

	assign avs_readdata = q_q.rdata;
	assign avs_waitrequest = ~q_q.wait_n;
	assign assessment_if_bandwidth = q_q.cfg_a[6:5];
	assign channel_busy_flag = q_q.cfg_a[`CCX_BIT_BUSY];
	assign assess_active = q_q.assess_run;
	assign tx_start = q_q.tx_start;
	assign radio_state = state_code(q_q.state);
	assign preamble_bytes = q_q.preamble;
	assign frame_delimiter = q_q.sfd;
	assign phy_header = q_q.phr;
	assign rx_buf_level = q_q.rxb_sig;
	assign rx_buf_size = q_q.rxb_size;
	assign tx_buf_level = q_q.txb_sig;
	assign tx_buf_size = q_q.txb_size;
	assign rx_antenna_cfg = q_q.rx_ant;
	assign tx_antenna_cfg = q_q.tx_ant;
	assign test_mode = q_q.testmode;

endmodule

`default_nettype wire

// >>> verification/ccx_regs_props.sv
// Port-level assertions for the CCA extension register bank
`timescale 1ns/1ps
`default_nettype none
module ccx_regs_props #(
	parameter int TICK_CYCLES = 50
)
(
	input wire logic clk_sys, // Clock
	input wire logic rst, // Reset
	input wire logic [8:0] avs_address, // Index
	input wire logic avs_read, // Read
	input wire logic avs_write, // Write
	input wire logic [3:0] avs_byteenable, // Lanes
	input wire logic [31:0] avs_writedata, // Data in
	input wire logic [31:0] avs_readdata, // Data out
	input wire logic avs_waitrequest, // Stall
	input wire logic rx_byte_strobe, // Byte seen
	input wire logic preamble_detected, // Preamble
	input wire logic sfd_detected, // Delimiter
	input wire logic [1:0] assessment_if_bandwidth, // Filter
	input wire logic channel_busy_flag, // Busy
	input wire logic tx_start, // Transmit
	input wire logic [7:0] radio_state, // State
	input wire logic [15:0] preamble_bytes, // Preamble
	input wire logic [15:0] frame_delimiter, // Delimiter
	input wire logic [15:0] phy_header // Header
);
	logic wr_ok;
	logic rd_ok;
	assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
	assign rd_ok = avs_read && !avs_waitrequest;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	a_bw_field_copy:
		assert property (wr_ok && avs_address == 9'h103 |=> assessment_if_bandwidth == $past(avs_writedata[6:5]))
		else $error("filter code not taken");
	a_busy_byte_only:
		assert property (!$past(rx_byte_strobe) |-> $stable(channel_busy_flag))
		else $error("busy moved without a byte");
	a_preamble_low_byte:
		assert property (wr_ok && avs_address == 9'h12e |=> preamble_bytes[7:0] == $past(avs_writedata[7:0]))
		else $error("preamble low byte wrong");
	a_delimiter_high_byte:
		assert property (wr_ok && avs_address == 9'h131 |=> frame_delimiter[15:8] == $past(avs_writedata[7:0]))
		else $error("delimiter high byte wrong");
	a_header_low_byte:
		assert property (wr_ok && avs_address == 9'h132 |=> phy_header[7:0] == $past(avs_writedata[7:0]))
		else $error("header low byte wrong");
	a_status_bits_read:
		assert property (rd_ok && avs_address == 9'h01f |->
			avs_readdata[1:0] == {$past(sfd_detected, 2), $past(preamble_detected, 2)})
		else $error("detect status read wrong");
	a_assess_cmd_entry:
		assert property (wr_ok && avs_address == 9'h0f0 && avs_writedata[7:0] == 8'hb2 |=> radio_state == 8'h1a)
		else $error("assess command ignored");
	a_tx_start_pulse:
		assert property (tx_start |-> radio_state == 8'h1c ##1 !tx_start)
		else $error("transmit start malformed");
	cover property (rx_byte_strobe && radio_state == 8'h1a);
	cover property (tx_start);
	cover property (rd_ok && avs_address == 9'h01f);
endmodule
bind ccx_regs ccx_regs_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (.clk_sys(clk_sys), .rst(rst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
	.avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.rx_byte_strobe(rx_byte_strobe), .preamble_detected(preamble_detected), .sfd_detected(sfd_detected),
	.assessment_if_bandwidth(assessment_if_bandwidth), .channel_busy_flag(channel_busy_flag),
	.tx_start(tx_start), .radio_state(radio_state), .preamble_bytes(preamble_bytes),
	.frame_delimiter(frame_delimiter), .phy_header(phy_header));
`default_nettype wire

// >>> verification/ccx_host_model.sv
// Host processor model issuing single Avalon-MM register transfers
`timescale 1ns/1ps
`default_nettype none
module ccx_host_model (
	input wire logic clk_sys, // Clock
	output logic [8:0] avs_address, // Index
	output logic avs_read, // Read
	output logic avs_write, // Write
	output logic [31:0] avs_writedata, // Data out
	input wire logic [31:0] avs_readdata, // Data in
	input wire logic avs_waitrequest, // Stall
	output logic host_hang // No answer came
);
	initial
	begin
		{avs_address, avs_read, avs_write, avs_writedata} = 43'h0;
		host_hang = 1'b0;
	end
	// Fields stay put until waitrequest is sampled low; a spare edge follows so no strobe is set twice at once
	task automatic xfer(input logic wr, input logic [8:0] a, input logic [7:0] d, output logic [7:0] q);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= {24'h000000, d};
		avs_read <= !wr;
		avs_write <= wr;
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0 && n < 100)
		begin
			n++;
			@(posedge clk_sys);
		end
		q = avs_readdata[7:0];
		host_hang <= (n >= 100);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk_sys);
	endtask
endmodule
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench for the CCA extension register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int TICK = 1;
	logic clk_sys, rst, rssi_valid, rssi_antenna, rx_byte_strobe, preamble_detected, sfd_detected, cal_valid, tx_done;
	logic avs_read, avs_write, avs_waitrequest, host_hang, busy, active, tx_start;
	logic [7:0] rssi_level, cal_band, cal_amplitude, state, q, rxl, rxs, txl, txs, rxa, txa, tm;
	logic [8:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [1:0] bw;
	logic [15:0] pre_w, sfd_w, phr_w;
	int n_mismatch, n_checks, cnt;
	int dur[7] = '{160, 320, 640, 1280, 1920, 2560, 9960};
	ccx_regs #(.TICK_CYCLES(TICK)) u_dut (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'h1), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rssi_valid(rssi_valid),
		.rssi_level(rssi_level), .rssi_antenna(rssi_antenna), .rx_byte_strobe(rx_byte_strobe),
		.preamble_detected(preamble_detected), .sfd_detected(sfd_detected), .cal_valid(cal_valid),
		.cal_band(cal_band), .cal_amplitude(cal_amplitude), .tx_done(tx_done), .assessment_if_bandwidth(bw),
		.channel_busy_flag(busy), .assess_active(active), .tx_start(tx_start), .radio_state(state),
		.preamble_bytes(pre_w), .frame_delimiter(sfd_w), .phy_header(phr_w), .rx_buf_level(rxl),
		.rx_buf_size(rxs), .tx_buf_level(txl), .tx_buf_size(txs), .rx_antenna_cfg(rxa), .tx_antenna_cfg(txa),
		.test_mode(tm));
	ccx_host_model u_host (.clk_sys(clk_sys), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .host_hang(host_hang));
	initial
	begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	task automatic chk(input string s, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", s, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		if (n_mismatch == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic hang();
		n_mismatch++;
		tally_and_finish();
	endtask
	always @(posedge host_hang) hang();
	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		u_host.xfer(1'b1, a, d, q);
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [8:0] a, input logic [7:0] d, input string s);
		u_host.xfer(1'b0, a, 8'h00, q);
		chk(s, {8'h00, q}, {8'h00, d});
	endtask
	// k: 0/1 level on antenna 0/1, 2 received byte, 3 calibration, 4 transmit finished
	task automatic pulse(input int k, input logic [7:0] v);
		rssi_level <= v;
		cal_band <= v;
		cal_amplitude <= ~v;
		rssi_valid <= (k < 2);
		rssi_antenna <= (k == 1);
		rx_byte_strobe <= (k == 2);
		cal_valid <= (k == 3);
		tx_done <= (k == 4);
		@(posedge clk_sys);
		{rssi_valid, rx_byte_strobe, cal_valid, tx_done} <= 4'h0;
		repeat (2) @(posedge clk_sys);
	endtask
	task automatic run(input logic [7:0] cfg);
		wr(9'h103, cfg);
		wr(9'h0f0, 8'hb7);
		cnt = 0;
		while (active === 1'b1 && cnt < 12000)
		begin
			cnt++;
			@(posedge clk_sys);
		end
		if (cnt >= 12000) hang();
	endtask
	task automatic s_regs();
		for (int i = 0; i < 10; i++)
			wr(9'h12e + 9'(i), 8'ha0 + 8'(i));
		chk("preamble", pre_w, 16'ha1a0);
		chk("delimiter", sfd_w, 16'ha3a2);
		chk("header", phr_w, 16'ha5a4);
		chk("rx_buffer", {rxl, rxs}, 16'ha6a7);
		chk("tx_buffer", {txl, txs}, 16'ha8a9);
		rd(9'h131, 8'ha3, "delimiter_high");
		wr(9'h12a, 8'h52);
		chk("tx_antenna", {8'h00, txa}, 16'h0052);
		wr(9'h139, 8'h3c);
		chk("test_mode", {8'h00, tm}, 16'h003c);
		wr(9'h138, 8'h5a);
		rd(9'h138, 8'h00, "reserved");
		wr(9'h100, 8'h5a);
		rd(9'h100, 8'h00, "unmapped");
	endtask
	task automatic s_side();
		wr(9'h129, 8'h01);
		chk("rx_antenna", {8'h00, rxa}, 16'h0001);
		pulse(0, 8'h33);
		pulse(1, 8'h44);
		wr(9'h129, 8'h00);
		pulse(0, 8'h77);
		rd(9'h12b, 8'h33, "antenna0");
		rd(9'h12c, 8'h44, "antenna1");
		pulse(3, 8'h2c);
		rd(9'h13b, 8'h2c, "band");
		rd(9'h13c, 8'hd3, "amplitude");
		preamble_detected <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rd(9'h01f, 8'h01, "rx_status");
		sfd_detected <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rd(9'h01f, 8'h03, "rx_status");
	endtask
	task automatic s_assess();
		for (int b = 0; b < 4; b++)
		begin
			wr(9'h103, {1'b0, 2'(b), 5'h10});
			chk("bandwidth", 16'(bw), 16'(b));
		end
		wr(9'h105, 8'h40);
		wr(9'h103, 8'h70); // Refresh bypass stays clear in normal use
		wr(9'h0f0, 8'hb2);
		chk("state", 16'(state), 16'h001a);
		pulse(2, 8'h50);
		chk("busy", 16'(busy), 16'h0001);
		rd(9'h12d, 8'hf0, "margin");
		rd(9'h103, 8'hf0, "config_a");
		pulse(2, 8'h40);
		chk("busy", 16'(busy), 16'h0000);
		pulse(2, 8'h41);
		chk("busy", 16'(busy), 16'h0001);
		wr(9'h103, 8'h71);
		pulse(2, 8'h10);
		chk("busy", 16'(busy), 16'h0001);
		wr(9'h103, 8'h70);
		pulse(2, 8'h10);
		chk("busy", 16'(busy), 16'h0000);
	endtask
	task automatic s_timer();
		for (int t = 0; t < 7; t++)
		begin
			run({4'h1, 3'(t), 1'b0});
			chk("duration", 16'(cnt >= dur[t] * TICK - 3 && cnt <= dur[t] * TICK + 3), 16'h0001);
		end
		chk("hold_state", 16'(state), 16'h001a);
		pulse(2, 8'h50);
		run(8'h00);
		chk("busy_no_tx", 16'(state), 16'h001a);
		pulse(2, 8'h10);
		run(8'h00);
		chk("tx_start", 16'(tx_start), 16'h0001);
		chk("auto_tx", 16'(state), 16'h001c);
		wr(9'h0f0, 8'hb2);
		chk("from_tx", 16'(state), 16'h001a);
		wr(9'h0f0, 8'hb5);
		pulse(4, 8'h00);
		chk("idle", 16'(state), 16'h0018);
		wr(9'h0f0, 8'hb2);
		chk("from_idle", 16'(state), 16'h001a);
		wr(9'h103, 8'h1e);
		wr(9'h0f0, 8'hb7);
		repeat (300) @(posedge clk_sys);
		chk("endless", 16'(active), 16'h0001);
		wr(9'h0f0, 8'hb8);
		chk("stopped", 16'(active), 16'h0000);
	endtask
	initial
	begin
		rst = 1'b1;
		{rssi_valid, rssi_antenna, rx_byte_strobe, preamble_detected, sfd_detected, cal_valid, tx_done} = 7'h00;
		{rssi_level, cal_band, cal_amplitude} = 24'h000000;
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		s_regs();
		s_side();
		s_assess();
		s_timer();
		tally_and_finish();
	end
endmodule
`default_nettype wire
